/* File: wdg_defines.vh */
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

// register byte offsets
`define WDG_CTRL_OFS      12'h000
`define WDG_WAKE_OFS      12'h004
`define WDG_STAT_OFS      12'h008
`define WDG_MASK_OFS      12'h00C

// guard_control_reg fields
`define WDG_CLR_BIT       0
`define WDG_RSTEN_BIT     1
`define WDG_EN_BIT        7
`define WDG_SEL_LSB       8
`define WDG_SEL_MSB       10

// wakeup_enable_reg field
`define WDG_WAKEEN_BIT    4

// status and mask layout
`define WDG_ST_TMO        0
`define WDG_ST_WAKE       1
`define WDG_ST_CAUSE      2
`define WDG_ST_W          3

// reset values
`define WDG_CTRL_RST      32'h00000000
`define WDG_SEL_RST       3'h0
`define WDG_STAT_RST      3'h0
`define WDG_MASK_RST      3'h0

// counter and timing, in guard clock periods
`define WDG_CNT_W         18
`define WDG_BASE_EXP      5'h04
`define WDG_GRACE_TICKS   1024
`define WDG_GRACE_W       11
`define WDG_RST_TICKS     63
`define WDG_RST_W         6

// restart address of the processor after a guard reset
`define WDG_RESET_VECTOR  32'h00000000

`endif

/* File: wdg_timer.v */
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`include "wdg_defines.vh"
// Operation
// [RULE_01] 18-bit up-counter on guard clock
// [RULE_02] enable bit 7 starts counting
// [RULE_03] timeout sets flag; irq only if enabled
// [RULE_04] 1024-clock grace after each timeout; a timeout inside an open window does not restart it
// [RULE_05] bit 0 clears counter, self-clears
// [RULE_06] select bits 10:8 choose eight intervals
// [RULE_07] code 000 gives 2^4, 111 gives 2^18
// [RULE_08] grace expiry sets cause flag, resets chip
// [RULE_09] chip reset lasts 63 guard clocks
// [RULE_10] cause flag survives guard reset
// [RULE_11] wake from power-down at interval
// [RULE_12] after wake, clear within 1024 clocks
// [RULE_13] code 110 gives 2^16
// [RULE_14] reset only when reset-enable set
module wdg_timer
#(
  parameter GUARD_DIV = 1,
  parameter DIV_W     = 8
)
(
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        powerDown,
  output wire        wakeReq,
  output wire        chipReset,
  output wire        irq
);

  // last value of each counter, cut to the counter width
  localparam integer            DIV_END    = GUARD_DIV - 1;
  localparam integer            GRACE_END  = `WDG_GRACE_TICKS - 1;
  localparam integer            RST_END    = `WDG_RST_TICKS - 1;
  localparam [DIV_W-1:0]        DIV_LAST   = DIV_END[DIV_W-1:0];
  localparam [`WDG_GRACE_W-1:0] GRACE_LAST = GRACE_END[`WDG_GRACE_W-1:0];
  localparam [`WDG_RST_W-1:0]   RST_LAST   = RST_END[`WDG_RST_W-1:0];

  // control fields
  reg                      guardEnable_r;
  reg                      resetEnable_r;
  reg [2:0]                intervalSel_r;
  reg                      clearReq_r;
  reg                      wakeEnable_r;

  // status, mask and registered outputs
  reg [`WDG_ST_W-1:0]      status_r;
  reg [`WDG_ST_W-1:0]      mask_r;
  reg                      irq_r;
  reg                      wakeReq_r;
  reg [31:0]               prdata_r;

  // guard counters
  reg [`WDG_CNT_W-1:0]     count_r;
  reg                      graceOn_r;
  reg [`WDG_GRACE_W-1:0]   graceCnt_r;
  reg                      rstOn_r;
  reg [`WDG_RST_W-1:0]     rstCnt_r;
  reg [DIV_W-1:0]          divCnt_r;

  // read decode
  reg [31:0]               readMux;
  reg                      addrOk;

  // guard events
  wire                     tick;
  wire [`WDG_CNT_W-1:0]    selMask;
  wire                     timeoutHit;
  wire                     graceExpire;
  wire                     rstStart;
  wire                     rstEnd;
  wire                     wakeHit;

  // bus strobes
  wire                     apbWrite;
  wire                     apbSetupRead;
  wire                     ctrlWrite;
  wire                     wakeWrite;
  wire                     statWrite;
  wire                     maskWrite;

  // status terms
  wire [`WDG_ST_W-1:0]     statusSet;
  wire [`WDG_ST_W-1:0]     statusClr;
  wire [`WDG_ST_W-1:0]     statusKeep;
  wire [`WDG_ST_W-1:0]     status_nxt;
  genvar                   gi;

  // mask of low bits for interval 2^(4 + 2*sel)
  function [`WDG_CNT_W-1:0] interval_mask;
    input [2:0] sel;
    reg   [4:0] expo;
    begin
      expo = `WDG_BASE_EXP + {1'b0, sel, 1'b0};
      interval_mask = ({{(`WDG_CNT_W-1){1'b0}}, 1'b1} << expo) - 1'b1;
    end
  endfunction

  // guard clock tick from the system clock
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      divCnt_r <= {DIV_W{1'b0}};
    else if (divCnt_r == DIV_LAST)
      divCnt_r <= {DIV_W{1'b0}};
    else
      divCnt_r <= divCnt_r + 1'b1;
  end

  assign tick = (divCnt_r == DIV_LAST);

  // interval decode; 110 -> 2^16, 111 -> 2^18
  assign selMask = interval_mask(intervalSel_r); // [RULE_06] [RULE_07] [RULE_13]

  // timeout when low interval bits are all ones on a tick
  assign timeoutHit = guardEnable_r & tick & ~clearReq_r & ~rstOn_r &
                      ((count_r & selMask) == selMask); // [RULE_03]

  assign graceExpire = graceOn_r & tick & (graceCnt_r == GRACE_LAST);
  assign rstStart    = graceExpire & resetEnable_r; // [RULE_14]
  assign rstEnd      = rstOn_r & tick & (rstCnt_r == RST_LAST);
  assign wakeHit     = timeoutHit & powerDown & wakeEnable_r; // [RULE_11]

  // apb decode
  assign apbWrite     = psel & penable & pwrite;
  assign apbSetupRead = psel & ~penable & ~pwrite;

  // one write strobe per register, taken in the access cycle
  assign ctrlWrite = apbWrite & (paddr == `WDG_CTRL_OFS);
  assign wakeWrite = apbWrite & (paddr == `WDG_WAKE_OFS);
  assign statWrite = apbWrite & (paddr == `WDG_STAT_OFS);
  assign maskWrite = apbWrite & (paddr == `WDG_MASK_OFS);

  always @*
  begin
    addrOk = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `WDG_CTRL_OFS:
      begin
        readMux[`WDG_CLR_BIT] = clearReq_r;
        readMux[`WDG_RSTEN_BIT] = resetEnable_r;
        readMux[`WDG_EN_BIT] = guardEnable_r;
        readMux[`WDG_SEL_MSB:`WDG_SEL_LSB] = intervalSel_r;
      end
      `WDG_WAKE_OFS:
        readMux[`WDG_WAKEEN_BIT] = wakeEnable_r;
      `WDG_STAT_OFS:
        readMux[`WDG_ST_W-1:0] = status_r;
      `WDG_MASK_OFS:
        readMux[`WDG_ST_W-1:0] = mask_r;
      default:
        addrOk = 1'b0;
    endcase
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrOk;

  // read data captured in the setup cycle
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prdata_r <= 32'h00000000;
    else if (apbSetupRead)
      prdata_r <= readMux;
  end

  // control bits; guard reset end restores defaults
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      guardEnable_r <= 1'b0;
      resetEnable_r <= 1'b0;
      intervalSel_r <= `WDG_SEL_RST;
      wakeEnable_r  <= 1'b0;
      mask_r        <= `WDG_MASK_RST;
    end
    else if (rstEnd)
    begin
      guardEnable_r <= 1'b0;
      resetEnable_r <= 1'b0;
      intervalSel_r <= `WDG_SEL_RST;
      wakeEnable_r  <= 1'b0;
      mask_r        <= `WDG_MASK_RST;
    end
    else if (ctrlWrite)
    begin
      guardEnable_r <= pwdata[`WDG_EN_BIT]; // [RULE_02]
      resetEnable_r <= pwdata[`WDG_RSTEN_BIT];
      intervalSel_r <= pwdata[`WDG_SEL_MSB:`WDG_SEL_LSB];
    end
    else if (wakeWrite)
      wakeEnable_r <= pwdata[`WDG_WAKEEN_BIT];
    else if (maskWrite)
      mask_r <= pwdata[`WDG_ST_W-1:0];
  end

  // clear request lives one cycle, dropped once counter is zeroed
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      clearReq_r <= 1'b0;
    else if (clearReq_r)
      clearReq_r <= 1'b0; // [RULE_05]
    else if (ctrlWrite && !rstOn_r)
      clearReq_r <= pwdata[`WDG_CLR_BIT];
  end

  // up-counter, held at zero while disabled, clearing or in guard reset
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= {`WDG_CNT_W{1'b0}};
    else if (!guardEnable_r || clearReq_r || rstOn_r)
      count_r <= {`WDG_CNT_W{1'b0}}; // [RULE_05]
    else if (tick)
      count_r <= count_r + 1'b1; // [RULE_01] [RULE_02]
  end

  // grace window after a timeout, cancelled by a clear
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      graceOn_r  <= 1'b0;
      graceCnt_r <= {`WDG_GRACE_W{1'b0}};
    end
    else if (!guardEnable_r || clearReq_r || rstOn_r)
    begin
      graceOn_r  <= 1'b0; // [RULE_05] [RULE_12]
      graceCnt_r <= {`WDG_GRACE_W{1'b0}};
    end
    else if (graceExpire)
    begin
      graceOn_r  <= 1'b0;
      graceCnt_r <= {`WDG_GRACE_W{1'b0}};
    end
    else if (timeoutHit && !graceOn_r)
    begin
      graceOn_r  <= 1'b1; // [RULE_04] [RULE_12]
      graceCnt_r <= {`WDG_GRACE_W{1'b0}};
    end
    else if (graceOn_r && tick)
      graceCnt_r <= graceCnt_r + 1'b1; // [RULE_04]
  end

  // chip reset pulse of 63 guard clocks
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstOn_r  <= 1'b0;
      rstCnt_r <= {`WDG_RST_W{1'b0}};
    end
    else if (rstStart)
    begin
      rstOn_r  <= 1'b1; // [RULE_08]
      rstCnt_r <= {`WDG_RST_W{1'b0}};
    end
    else if (rstEnd)
    begin
      rstOn_r  <= 1'b0; // [RULE_09]
      rstCnt_r <= {`WDG_RST_W{1'b0}};
    end
    else if (rstOn_r && tick)
      rstCnt_r <= rstCnt_r + 1'b1; // [RULE_09]
  end

  // sticky status: set wins over write-one-to-clear
  assign statusSet = {rstStart, wakeHit, timeoutHit}; // [RULE_03] [RULE_08]
  assign statusClr = statWrite ? pwdata[`WDG_ST_W-1:0] : {`WDG_ST_W{1'b0}};

  // guard reset end drops all but the cause flag
  assign statusKeep = {1'b1, {(`WDG_ST_W-1){~rstEnd}}}; // [RULE_10]

  // one sticky flag per status bit
  generate
    for (gi = 0; gi < `WDG_ST_W; gi = gi + 1)
    begin : g_status
      assign status_nxt[gi] = ((status_r[gi] & ~statusClr[gi]) |
                               statusSet[gi]) & statusKeep[gi];
    end
  endgenerate

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      status_r <= `WDG_STAT_RST;
    else
      status_r <= status_nxt;
  end

  // level interrupt from unmasked status
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_nxt & mask_r); // [RULE_03]
  end

  // one-cycle wake request to the power controller
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wakeReq_r <= 1'b0;
    else
      wakeReq_r <= wakeHit; // [RULE_11]
  end

  assign prdata    = prdata_r;
  assign wakeReq   = wakeReq_r;
  assign chipReset = rstOn_r; // [RULE_08] [RULE_09]
  assign irq       = irq_r;

endmodule

/* File: wdg_timer_assertions.sv */
`timescale 1ns/1ns
module wdg_timer_assertions (
  input wire        clk_sys,
  input wire        reset_n,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        powerDown,
  input wire        wakeReq,
  input wire        chipReset,
  input wire        irq
);
  reg  [6:0] highCnt_r;
  wire       unmapped;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // address outside the four words
  assign unmapped = paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0;
  // length of the current guard reset
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      highCnt_r <= 7'h00;
    else
      highCnt_r <= chipReset ? highCnt_r + 7'h01 : 7'h00;
  rst_len_a: assert property (
    $fell(chipReset) |-> highCnt_r == 7'h3F) else $error("reset length");
  rst_cap_a: assert property (
    highCnt_r <= 7'h3F) else $error("reset too long");
  wake_pulse_a: assert property (
    wakeReq |=> !wakeReq) else $error("wake pulse too long");
  wake_cause_a: assert property (
    wakeReq |-> $past(powerDown)) else $error("wake while running");
  ready_high_a: assert property (
    psel && penable |-> pready) else $error("pready low");
  slverr_map_a: assert property (
    psel && penable |-> pslverr == unmapped) else $error("pslverr wrong");
  unmap_read_a: assert property (
    psel && !penable && !pwrite && unmapped |=> prdata == 32'h00000000)
    else $error("unmapped read data");
  wake_read_a: assert property (
    psel && !penable && !pwrite && paddr == 12'h004
    |=> (prdata & 32'hFFFFFFEF) == 32'h00000000) else $error("wake bits");
  mask_off_a: assert property (
    psel && penable && pwrite && paddr == 12'h00C && pwdata[2:0] == 3'h0
    |-> ##2 !irq) else $error("irq while masked");
endmodule
bind wdg_timer wdg_timer_assertions chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .powerDown(powerDown), .wakeReq(wakeReq),
  .chipReset(chipReset), .irq(irq));

/* File: wdg_timer_bench.sv */
`timescale 1ns/1ns
module wdg_timer_bench;
  reg         clk_sys;
  reg         reset_n;
  reg  [11:0] paddr;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [31:0] pwdata;
  reg         powerDown;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        wakeReq;
  wire        chipReset;
  wire        irq;
  integer     badCount;
  integer     checkCount;
  integer     cycles;
  integer     n;
  integer     i;
  reg  [31:0] rd;
  reg         errSeen;
  reg         rstSeen;
  wdg_timer #(.GUARD_DIV(1)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerDown(powerDown), .wakeReq(wakeReq), .chipReset(chipReset),
    .irq(irq));
  // clock
  always #2 clk_sys = ~clk_sys;
  // hang guard and guard reset watch
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (chipReset === 1'b1)
      rstSeen = 1'b1;
    if (cycles == 99000)
    begin
      badCount = badCount + 1;
      completeRun;
    end
  end
  task completeRun;
  begin
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input [8*12:1] what, input [31:0] exp, input [31:0] got);
  begin
    checkCount = checkCount + 1;
    if (got !== exp)
    begin
      badCount = badCount + 1;
      $display("BAD %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // one apb transfer, held until pready
  task xfer(input wr, input [11:0] a, input [31:0] d);
  begin
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // edges until wake, irq or reset reaches lvl
  task waitFor(input integer which, input lvl, output integer p);
    reg s;
  begin
    p = 0;
    s = ~lvl;
    while (s !== lvl)
    begin
      @(posedge clk_sys);
      p = p + 1;
      s = (which == 0) ? wakeReq : (which == 1) ? irq : chipReset;
    end
  end
  endtask
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    powerDown = 1'b0;
    badCount = 0;
    checkCount = 0;
    cycles = 0;
    rstSeen = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      xfer(1'b0, {i[9:0], 2'b00}, 32'h00000000);
      chk("reset value", 32'h00000000, rd);
    end
    chk("unmapped", 32'h00000001, {31'h0, errSeen});
    xfer(1'b1, 12'h004, 32'hFFFFFFFF);
    xfer(1'b0, 12'h004, 32'h00000000);
    chk("wake enable", 32'h00000010, rd);
    xfer(1'b1, 12'h00C, 32'hFFFFFFFF);
    xfer(1'b0, 12'h00C, 32'h00000000);
    chk("mask", 32'h00000007, rd);
    powerDown <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      xfer(1'b1, 12'h000, 32'h00000000);
      xfer(1'b1, 12'h000, {21'h0, i[2:0], 8'h80});
      waitFor(0, 1'b1, n);
      waitFor(0, 1'b1, n);
      chk("interval", 32'h1 << (4 + 2 * i), n);
    end
    xfer(1'b1, 12'h000, 32'h00000700);
    xfer(1'b0, 12'h000, 32'h00000000);
    chk("select 111", 32'h00000700, rd);
    chk("irq set", 32'h1, {31'h0, irq});
    xfer(1'b0, 12'h008, 32'h00000000);
    chk("status", 32'h00000003, rd);
    chk("no reset", 32'h0, {31'h0, rstSeen});
    powerDown <= 1'b0;
    xfer(1'b1, 12'h000, 32'h00000082);
    repeat (3)
    begin
      repeat (600) @(posedge clk_sys);
      xfer(1'b1, 12'h000, 32'h00000083);
    end
    xfer(1'b0, 12'h000, 32'h00000000);
    chk("clear bit", 32'h00000082, rd);
    chk("early reset", 32'h0, {31'h0, rstSeen});
    xfer(1'b1, 12'h008, 32'h00000007);
    waitFor(1, 1'b1, n);
    waitFor(2, 1'b1, n);
    chk("grace", 32'd1024, n);
    waitFor(2, 1'b0, n);
    chk("reset len", 32'd63, n);
    xfer(1'b0, 12'h008, 32'h00000000);
    chk("cause", 32'h00000004, rd);
    xfer(1'b0, 12'h000, 32'h00000000);
    chk("ctrl after", 32'h00000000, rd);
    xfer(1'b1, 12'h00C, 32'h00000004);
    repeat (2) @(posedge clk_sys);
    chk("cause irq", 32'h1, {31'h0, irq});
    xfer(1'b1, 12'h00C, 32'h00000000);
    repeat (2) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, 12'h00C, 32'h00000004);
    xfer(1'b1, 12'h008, 32'h00000004);
    xfer(1'b0, 12'h008, 32'h00000000);
    chk("cleared", 32'h00000000, rd);
    chk("irq off", 32'h0, {31'h0, irq});
    completeRun;
  end
endmodule
